// ### mdc_diag_counters.sv
// mdc_diag_counters: serial bus slave diagnostic counters and 08H responder
// assumes frame and reply events arrive as single-cycle strobes, one per frame
`timescale 1ns/1ps
`default_nettype none

module mdc_diag_counters
  import mdc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire mdc_frame_ev_s frame_ev_i,
  input wire mdc_reply_ev_s reply_ev_i,
  input wire mdc_req_s req_i,
  output mdc_rsp_s rsp_o,
  output logic busy_o,
  output logic [15:0] diag_reg_o
);

  // ==========================================================
  // counter events
  logic [MDC_NUM_CNT-1:0] inc;
  logic clear_now;
  logic [15:0] cnt_reg [MDC_NUM_CNT];
  logic [15:0] cnt_next [MDC_NUM_CNT];
  logic [15:0] diag_reg;
  logic [15:0] diag_next;

  always_comb begin
    inc = '0;
    // one strobe per frame, so one increment per message
    inc[MDC_IDX_BUS_MSG] = frame_ev_i.frame_end;
    inc[MDC_IDX_CRC_ERR] = frame_ev_i.frame_end & frame_ev_i.crc_bad;
    inc[MDC_IDX_SLV_MSG] = frame_ev_i.frame_end & ~frame_ev_i.crc_bad &
      (frame_ev_i.addr_own | frame_ev_i.addr_bcast);
    inc[MDC_IDX_OVR] = frame_ev_i.frame_end & frame_ev_i.addr_own &
      frame_ev_i.overrun;
    // reply strobes concern own-address or broadcast messages only
    inc[MDC_IDX_EXC] = reply_ev_i.sent & reply_ev_i.exc;
    inc[MDC_IDX_NO_RSP] = reply_ev_i.sent & reply_ev_i.none;
    inc[MDC_IDX_NAK] = reply_ev_i.sent & reply_ev_i.exc &
      (reply_ev_i.exc_code == MDC_EXC_NAK);
    inc[MDC_IDX_BUSY] = reply_ev_i.sent & reply_ev_i.exc &
      (reply_ev_i.exc_code == MDC_EXC_BUSY);
  end

  genvar gi;
  generate
    for (gi = 0; gi < MDC_NUM_CNT; gi++) begin : g_cnt
      always_comb begin
        if (clear_now) begin
          cnt_next[gi] = MDC_CNT_RESET;
        end else if (inc[gi]) begin
          cnt_next[gi] = cnt_reg[gi] + 16'h0001;
        end else begin
          cnt_next[gi] = cnt_reg[gi];
        end
      end
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          cnt_reg[gi] <= MDC_CNT_RESET;
        end else begin
          cnt_reg[gi] <= cnt_next[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    diag_next = clear_now ? MDC_CNT_RESET : diag_reg;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      diag_reg <= MDC_CNT_RESET;
    end else begin
      diag_reg <= diag_next;
    end
  end

  assign diag_reg_o = diag_reg;

  // ==========================================================
  // request handling
  mdc_state_e state_reg;
  mdc_state_e state_next;
  mdc_req_s req_reg;
  mdc_req_s req_next;
  mdc_rsp_s rsp_reg;
  mdc_rsp_s rsp_next;
  logic [3:0] sel;
  logic in_range;

  assign in_range = (req_reg.sub_func >= MDC_SUB_CLEAR) &&
    (req_reg.sub_func <= MDC_SUB_LAST);
  assign sel = 4'(req_reg.sub_func - MDC_SUB_FIRST);
  assign clear_now = (state_reg == MDC_SEL) && !req_reg.bcast &&
    (req_reg.sub_func == MDC_SUB_CLEAR) &&
    (req_reg.data == MDC_DATA_ZERO);

  always_comb begin
    state_next = state_reg;
    req_next = req_reg;
    rsp_next = rsp_reg;
    rsp_next.valid = 1'b0;
    unique case (state_reg)
      MDC_IDLE: begin
        if (req_i.valid && !req_i.bcast) begin
          req_next = req_i;
          state_next = MDC_SEL;
        end
      end
      MDC_SEL: begin
        rsp_next.func = MDC_FUNC_DIAG;
        rsp_next.sub_func = req_reg.sub_func;
        rsp_next.exc = 1'b0;
        rsp_next.exc_code = 8'h00;
        rsp_next.value = MDC_CNT_RESET;
        if (!in_range) begin
          rsp_next.exc = 1'b1;
          rsp_next.func = MDC_FUNC_DIAG | MDC_EXC_FLAG;
          rsp_next.exc_code = MDC_EXC_ILL_FUNC;
        end else if (req_reg.data != MDC_DATA_ZERO) begin
          rsp_next.exc = 1'b1;
          rsp_next.func = MDC_FUNC_DIAG | MDC_EXC_FLAG;
          rsp_next.exc_code = MDC_EXC_ILL_VAL;
        end else if (req_reg.sub_func != MDC_SUB_CLEAR) begin
          rsp_next.value = cnt_reg[sel[2:0]];
        end
        rsp_next.valid = 1'b1;
        state_next = MDC_ANS;
      end
      MDC_ANS: begin
        state_next = MDC_IDLE;
      end
      default: state_next = MDC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= MDC_IDLE;
      req_reg <= '0;
      rsp_reg <= '0;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      rsp_reg <= rsp_next;
    end
  end

  assign rsp_o = rsp_reg;
  assign busy_o = (state_reg != MDC_IDLE);

  // ==========================================================
  // checks
  property p_clear_zero;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clear_now |=> (cnt_reg[MDC_IDX_BUS_MSG] == 16'h0000) &&
        (cnt_reg[MDC_IDX_OVR] == 16'h0000);
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("counters not cleared");

  property p_bus_inc;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (frame_ev_i.frame_end && !clear_now) |=>
        cnt_reg[MDC_IDX_BUS_MSG] == $past(cnt_reg[MDC_IDX_BUS_MSG]) + 16'h1;
  endproperty
  a_bus_inc: assert property (p_bus_inc)
    else $error("bus message count wrong");

  property p_crc_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (!frame_ev_i.crc_bad && !clear_now) |=>
        $stable(cnt_reg[MDC_IDX_CRC_ERR]);
  endproperty
  a_crc_hold: assert property (p_crc_hold)
    else $error("crc count moved without error");

  property p_nak_inc;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (inc[MDC_IDX_NAK] && !clear_now) |=>
        cnt_reg[MDC_IDX_NAK] != $past(cnt_reg[MDC_IDX_NAK]);
  endproperty
  a_nak_inc: assert property (p_nak_inc)
    else $error("nak count not advanced");

  property p_range;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (rsp_o.valid && !rsp_o.exc) |->
        rsp_o.sub_func >= 16'h000A && rsp_o.sub_func <= 16'h0012;
  endproperty
  a_range: assert property (p_range)
    else $error("out of range sub-function answered");

  property p_echo;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_reg == MDC_SEL) |=> rsp_o.valid &&
        rsp_o.sub_func == $past(req_reg.sub_func);
  endproperty
  a_echo: assert property (p_echo)
    else $error("reply does not echo sub-function");

  property p_bcast;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_reg == MDC_IDLE && req_i.valid && req_i.bcast) |=>
        state_reg == MDC_IDLE;
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("broadcast diagnostic accepted");

  property p_wrap;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (cnt_reg[MDC_IDX_BUS_MSG] == 16'hFFFF && inc[MDC_IDX_BUS_MSG] &&
        !clear_now) |=> cnt_reg[MDC_IDX_BUS_MSG] == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap");

  property p_ans_2cyc;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_reg == MDC_IDLE && req_i.valid && !req_i.bcast) |=>
        ##1 rsp_o.valid;
  endproperty
  a_ans_2cyc: assert property (p_ans_2cyc)
    else $error("answer late");

  c_clear: cover property (@(posedge sys_clk_i) clear_now);
  c_exc: cover property (@(posedge sys_clk_i) rsp_o.valid && rsp_o.exc);
  c_read: cover property (@(posedge sys_clk_i)
    rsp_o.valid && !rsp_o.exc && rsp_o.value != 16'h0000);

endmodule // mdc_diag_counters

`default_nettype wire

// ### mdc_host_model.sv
// mdc_host_model: far-side master and frame layer event source
// assumes the bench supplies a random word and an enable each cycle
`timescale 1ns/1ps
`default_nettype none
module mdc_host_model
  import mdc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic en_i,
  input wire logic [31:0] rnd_i,
  output var mdc_frame_ev_s frame_ev_o,
  output var mdc_reply_ev_s reply_ev_o
);
  // ==========================================
  // frame and reply generation
  logic pend = 1'b0;
  mdc_reply_ev_s pr;
  logic crc, own, bc, ovr, nr, ex;
  initial frame_ev_o = '0;
  initial reply_ev_o = '0;
  always_comb begin
    crc = rnd_i[1] & rnd_i[2];
    own = rnd_i[3];
    bc = ~own & rnd_i[4];
    ovr = own & ~crc & rnd_i[5] & rnd_i[6];
    nr = bc | ovr | (rnd_i[7] & rnd_i[8]);
    ex = ~nr & rnd_i[9];
  end
  always @(negedge sys_clk_i) begin
    // idle payload fields toggle while frame_end and sent stay low, so stale values never look valid
    frame_ev_o <= ~frame_ev_o & 5'h0F;
    reply_ev_o <= ~reply_ev_o & 11'h3FF;
    pend <= 1'b0;
    if (pend) begin
      reply_ev_o <= pr;
    end else if (en_i & rnd_i[0]) begin
      frame_ev_o <= {1'b1, crc, own, bc, ovr};
      pend <= ~crc & (own | bc);
      pr <= {1'b1, nr, ex, !ex ? 8'h00 : rnd_i[10] ? MDC_EXC_NAK :
             rnd_i[11] ? MDC_EXC_BUSY : MDC_EXC_ILL_VAL};
    end
  end
endmodule // mdc_host_model
`default_nettype wire

// ### mdc_pkg.sv
// mdc_pkg: constants and carriers for the diagnostic counter unit
// assumes a frame layer that reports per-message events as one-cycle pulses
package mdc_pkg;

  localparam int MDC_CNT_W = 16;
  localparam int MDC_NUM_CNT = 8;
  localparam logic [7:0] MDC_FUNC_DIAG = 8'h08;
  localparam logic [7:0] MDC_EXC_FLAG = 8'h80;
  localparam logic [15:0] MDC_SUB_CLEAR = 16'h000A;
  localparam logic [15:0] MDC_SUB_FIRST = 16'h000B;
  localparam logic [15:0] MDC_SUB_LAST = 16'h0012;
  localparam logic [15:0] MDC_DATA_ZERO = 16'h0000;
  localparam logic [15:0] MDC_CNT_RESET = 16'h0000;
  localparam logic [7:0] MDC_EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] MDC_EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] MDC_EXC_ILL_VAL = 8'h03;

  // counter slots, in sub-function order from 0BH
  localparam int MDC_IDX_BUS_MSG = 0;
  localparam int MDC_IDX_CRC_ERR = 1;
  localparam int MDC_IDX_EXC = 2;
  localparam int MDC_IDX_SLV_MSG = 3;
  localparam int MDC_IDX_NO_RSP = 4;
  localparam int MDC_IDX_NAK = 5;
  localparam int MDC_IDX_BUSY = 6;
  localparam int MDC_IDX_OVR = 7;

  // per-frame outcome reported by the frame layer at end of frame
  typedef struct packed {
    logic frame_end;     // one-cycle strobe: a frame was detected
    logic crc_bad;       // frame failed the check
    logic addr_own;      // frame carried this slave's address
    logic addr_bcast;    // frame carried the broadcast address
    logic overrun;       // receive character overrun in this frame
  } mdc_frame_ev_s;

  // reply outcome reported by the responder
  typedef struct packed {
    logic sent;          // one-cycle strobe: a reply decision was made
    logic none;          // no reply was sent
    logic exc;           // reply was an exception
    logic [7:0] exc_code;
  } mdc_reply_ev_s;

  // diagnostic request, fields already assembled MSB first
  typedef struct packed {
    logic valid;
    logic bcast;
    logic [15:0] sub_func;
    logic [15:0] data;
  } mdc_req_s;

  // diagnostic answer
  typedef struct packed {
    logic valid;
    logic exc;
    logic [7:0] func;
    logic [15:0] sub_func;
    logic [15:0] value;
    logic [7:0] exc_code;
  } mdc_rsp_s;

  typedef enum logic [1:0] {
    MDC_IDLE = 2'b00,
    MDC_SEL = 2'b01,
    MDC_ANS = 2'b11
  } mdc_state_e;

  localparam logic [7:0] MDC_EXC_NAK = 8'h07;
  localparam logic [7:0] MDC_EXC_BUSY = 8'h06;

endpackage : mdc_pkg

// ### testbench.sv
// testbench: random event traffic with diagnostic reads of every counter
// assumes the host model as the far side, one clock at 250 MHz
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mdc_pkg::*;
  // ==========================================
  // signals and instances
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic en = 1'b0;
  logic [31:0] rnd = '0;
  integer seed = 14;
  integer mismatches = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer i, r;
  mdc_frame_ev_s fe;
  mdc_reply_ev_s re;
  mdc_req_s req = '0;
  mdc_rsp_s rsp, ex;
  logic busy;
  logic [15:0] dreg;
  logic [15:0] cnt [8];
  mdc_host_model mdc_host_model_inst(.sys_clk_i(sys_clk_i), .en_i(en),
    .rnd_i(rnd), .frame_ev_o(fe), .reply_ev_o(re));
  mdc_diag_counters mdc_diag_counters_inst(.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .frame_ev_i(fe), .reply_ev_i(re), .req_i(req),
    .rsp_o(rsp), .busy_o(busy), .diag_reg_o(dreg));
  initial forever #2 sys_clk_i = ~sys_clk_i;
  always @(negedge sys_clk_i) rnd <= $random(seed);
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      close_out;
    end
  end
  // ==========================================
  // expected counter model
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt <= '{default: MDC_CNT_RESET};
    end else begin
      if (fe.frame_end) cnt[0] <= cnt[0] + 16'h0001;
      if (fe.frame_end & fe.crc_bad) cnt[1] <= cnt[1] + 16'h0001;
      if (fe.frame_end & fe.overrun & fe.addr_own)
        cnt[7] <= cnt[7] + 16'h0001;
      if (re.sent) cnt[3] <= cnt[3] + 16'h0001;
      if (re.sent & re.none) cnt[4] <= cnt[4] + 16'h0001;
      if (re.sent & re.exc) cnt[2] <= cnt[2] + 16'h0001;
      if (re.sent & re.exc & (re.exc_code == MDC_EXC_NAK))
        cnt[5] <= cnt[5] + 16'h0001;
      if (re.sent & re.exc & (re.exc_code == MDC_EXC_BUSY))
        cnt[6] <= cnt[6] + 16'h0001;
    end
  end
  function automatic mdc_rsp_s exp_rsp(logic [15:0] s, logic [15:0] d);
    mdc_rsp_s x;
    x = '0;
    x.valid = 1'b1;
    x.func = MDC_FUNC_DIAG;
    x.sub_func = s;
    if (s < MDC_SUB_CLEAR || s > MDC_SUB_LAST) begin
      x.exc = 1'b1;
      x.exc_code = MDC_EXC_ILL_FUNC;
    end else if (d != MDC_DATA_ZERO) begin
      x.exc = 1'b1;
      x.exc_code = MDC_EXC_ILL_VAL;
    end else if (s != MDC_SUB_CLEAR) begin
      x.value = cnt[3'(s - MDC_SUB_FIRST)];
    end
    if (x.exc) x.func = MDC_FUNC_DIAG | MDC_EXC_FLAG;
    return x;
  endfunction
  // ==========================================
  // tasks
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task req_t(input logic [15:0] s, input logic [15:0] d, input logic b);
    ex = exp_rsp(s, d);
    @(negedge sys_clk_i);
    req <= {1'b1, b, s, d};
    @(negedge sys_clk_i);
    req <= {2'b00, ~s, ~d};
    chk("busy", !b, busy);
    chk("early", 0, rsp.valid);
    @(negedge sys_clk_i);
    chk("valid", !b, rsp.valid);
    if (!b) begin
      chk("exc", ex.exc, rsp.exc);
      chk("func", ex.func, rsp.func);
      if (ex.exc) chk("code", ex.exc_code, rsp.exc_code);
      else chk("sub", s, rsp.sub_func);
      if (!ex.exc) chk("value", ex.value, rsp.value);
      if (!ex.exc && s == MDC_SUB_CLEAR) cnt = '{default: 16'h0000};
    end
    @(negedge sys_clk_i);
    chk("idle", 0, busy);
  endtask
  task read_all;
    for (i = 0; i < MDC_NUM_CNT; i++) begin
      req_t(MDC_SUB_FIRST + 16'(i), 16'h0000, 0);
    end
  endtask
  task traffic(input integer n);
    en <= 1'b1;
    repeat (n) @(negedge sys_clk_i);
    en <= 1'b0;
    repeat (3) @(negedge sys_clk_i);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(negedge sys_clk_i);
    rst_n_i <= 1'b1;
    read_all;
    for (r = 0; r < 4; r++) begin
      traffic(150 + 50 * r);
      read_all;
      if (r[0]) begin
        req_t(MDC_SUB_CLEAR, MDC_DATA_ZERO, 0);
        read_all;
        chk("diag", 0, dreg);
      end
    end
    traffic(100);
    // random sub-functions around the legal span, some bad data, some bcast
    for (i = 0; i < 24; i++) begin
      req_t(16'h0008 + 16'(rnd[31:16] % 16'h000E),
        (rnd[1:0] == 2'h0) ? 16'h0004 : 16'h0000, rnd[2] & rnd[3]);
    end
    read_all;
    req_t(16'h0009, 16'h0000, 0);
    req_t(16'h0013, 16'h0000, 0);
    req_t(16'hFFFF, 16'h0000, 0);
    req_t(MDC_SUB_CLEAR, 16'h0001, 0);
    req_t(MDC_SUB_FIRST, 16'h8000, 0);
    req_t(MDC_SUB_CLEAR, 16'h0000, 1);
    read_all;
    traffic(60);
    rst_n_i <= 1'b0;
    repeat (2) @(negedge sys_clk_i);
    rst_n_i <= 1'b1;
    read_all;
    close_out;
  end
endmodule // testbench
`default_nettype wire
